// ===== dgc_general_config.sv
// general configuration register, slew control and waveform generator
// Functional notes
// R1 - configuration register resets to 01f0h
// R2 - select 00 gives triangle between limit codes at step slope
// R3 - select 01 gives rising sawtooth, immediate return to lower code
// R4 - select 10 gives falling sawtooth, immediate jump to upper code
// R5 - select 11 gives square wave, each half one step interval
// R6 - lock bit makes all registers refuse writes until unlocked
// R7 - writing key 0101 to trigger key field clears lock
// R8 - bit 12 enables pmbus command mode
// R9 - increment codes give 1,2,3,4,6,8,16,32 lsb per step
// R10 - interval codes scale 25.6us, 204.8us, 1.6384ms bases by 1..1.75
// R11 - codes 1101/1110 give 12us/4us; 1111 means no slewing (while run is set, 1111 still steps ramps by the increment and toggles the square every clock)
// R12 - powerdown 00 active, 01/11 10k pulldown, 10 high impedance
// R13 - powerdown field resets to high impedance
// R14 - reference select 0 supply, 1 internal 1.21v
// R15 - gain 1.5x..4x applies only with internal reference
// R16 - trigger run bit starts continuous waveform, clearing stops it
// R17 - unlock key at trigger bits 15:12, write only, reads zero
// R18 - slewing steps toward target per interval, clamped at target
// R19 - lock bit reads zero, other fields read back as written
`timescale 1ns/1ps
module dgc_general_config
	import dgc_pkg::*;
#(
	parameter int BASE0_CYCLES = BASE0_CYC,
	parameter int BASE1_CYCLES = BASE1_CYC,
	parameter int BASE2_CYCLES = BASE2_CYC
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [CODE_W-1:0] target_code_i,
	input wire logic [CODE_W-1:0] margin_high_i,
	input wire logic [CODE_W-1:0] margin_low_i,
	output logic [15:0] rdata_o,
	output logic [CODE_W-1:0] code_o,
	output logic locked_o,
	output logic waveform_run_o,
	output logic pmbus_en_o,
	output logic out_active_o,
	output logic out_pulldown_o,
	output logic out_hiz_o,
	output logic ref_internal_o,
	output logic [1:0] output_gain_o
);
	logic [15:0] cfg;
	logic lock;
	logic run;
	logic dir_up;
	logic sq_high;
	logic [CODE_W-1:0] code;
	logic [CNT_W-1:0] cnt;

	// register access decode
	wire cfg_hit = addr_i == ADDR_GENERAL_CONFIG;
	wire trig_hit = addr_i == ADDR_TRIGGER;
	wire cfg_wr = wr_en_i && cfg_hit && !lock; // R6
	wire trig_wr = wr_en_i && trig_hit && !lock; // R6
	wire unlock = wr_en_i && trig_hit && (wdata_i[KEY_LSB+:4] == UNLOCK_KEY); // R7
	wire [15:0] cfg_rd = {cfg[15:LOCK_BIT+1], 1'b0, cfg[LOCK_BIT-1:0]}; // R19
	// trigger reads zero, key included
	wire [15:0] next_rdata = cfg_hit ? cfg_rd : 16'h0000; // R17

	// field views
	wire [1:0] wsel = cfg[WSEL_LSB+:2];
	wire [2:0] inc_sel = cfg[INC_LSB+:3];
	wire [3:0] slew = cfg[SLEW_LSB+:4];
	wire [1:0] pdn = cfg[PDN_LSB+:2];
	wire no_slew = slew == SLEW_NONE; // R11

	// step size in lsb
	wire [5:0] inc = (inc_sel == 3'h0) ? 6'h01 :
		(inc_sel == 3'h1) ? 6'h02 :
		(inc_sel == 3'h2) ? 6'h03 :
		(inc_sel == 3'h3) ? 6'h04 :
		(inc_sel == 3'h4) ? 6'h06 :
		(inc_sel == 3'h5) ? 6'h08 :
		(inc_sel == 3'h6) ? 6'h10 : 6'h20; // R9

	// step interval in cycles: base plus base quarters times the scale code
	wire [CNT_W-1:0] base = (slew[3:2] == 2'h0) ? CNT_W'(BASE0_CYCLES) :
		(slew[3:2] == 2'h1) ? CNT_W'(BASE1_CYCLES) : CNT_W'(BASE2_CYCLES); // R10
	wire [CNT_W-1:0] quarter = base >> 2;
	wire [CNT_W-1:0] scaled = base + CNT_W'(quarter * slew[1:0]); // R10
	wire [CNT_W-1:0] interval = (slew == SLEW_4US) ? CNT_W'(STEP_4US_CYC) :
		(slew[3:2] == 2'h3) ? CNT_W'(STEP_12US_CYC) : scaled; // R11
	// no slew steps every cycle and leaves the counter empty for the first slewed step
	wire tick = (cnt == '0) || no_slew; // R11
	wire [CNT_W-1:0] next_cnt = no_slew ? '0 : tick ? interval - CNT_W'(1) : cnt - CNT_W'(1);

	// goal code for the current ramp
	wire [CODE_W-1:0] goal = !run ? target_code_i : // R18
		(wsel == 2'h1) ? margin_high_i : // R3
		(wsel == 2'h2) ? margin_low_i : // R4
		dir_up ? margin_high_i : margin_low_i; // R2
	wire at_goal = code == goal;
	wire [CODE_W:0] up_sum = {1'b0, code} + {{(CODE_W-5){1'b0}}, inc};
	wire [CODE_W:0] dn_dif = {1'b0, code} - {{(CODE_W-5){1'b0}}, inc};
	wire [CODE_W-1:0] up_step = (up_sum >= {1'b0, goal}) ? goal : up_sum[CODE_W-1:0]; // R18
	wire [CODE_W-1:0] dn_step = (dn_dif[CODE_W] || dn_dif[CODE_W-1:0] <= goal) ? goal :
		dn_dif[CODE_W-1:0]; // R18
	wire [CODE_W-1:0] step = (code < goal) ? up_step : dn_step;
	wire [CODE_W-1:0] ramp_next = (!run || !at_goal) ? step :
		(wsel == 2'h1) ? margin_low_i : // R3
		(wsel == 2'h2) ? margin_high_i : code; // R4
	wire [CODE_W-1:0] move = (no_slew && !run) ? goal : ramp_next; // R11
	wire [CODE_W-1:0] sq_code = sq_high ? margin_low_i : margin_high_i; // R5
	wire is_square = run && (wsel == 2'h3);
	wire [CODE_W-1:0] next_code = !tick ? code : is_square ? sq_code : move;
	wire next_dir = (tick && run && wsel == 2'h0 && at_goal) ? !dir_up : dir_up; // R2
	wire next_sq = (tick && is_square) ? !sq_high : sq_high; // R5

	// decoded output values
	wire next_pmbus = cfg[PMBUS_BIT]; // R8
	wire next_active = pdn == PDN_ACTIVE; // R12
	wire next_pulldown = pdn[0]; // R12
	wire next_hiz = pdn == PDN_HIZ; // R12
	wire next_ref = cfg[REF_BIT]; // R14
	wire [1:0] next_gain = next_ref ? cfg[GAIN_LSB+:2] : 2'h0; // R15

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cfg <= GENERAL_CONFIG_RESET; // R1 R13
		end
		else
		begin
			if (cfg_wr)
				cfg <= wdata_i;
		end
	end

	// unlock wins over a same-cycle lock write
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lock <= 1'b0;
		end
		else
		begin
			if (unlock)
				lock <= 1'b0; // R7
			else if (cfg_wr)
				lock <= wdata_i[LOCK_BIT]; // R6
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			run <= 1'b0;
		end
		else
		begin
			if (trig_wr)
				run <= wdata_i[RUN_BIT]; // R16
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			code <= '0;
		end
		else
		begin
			code <= next_code; // R16 R18
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt <= '0;
		end
		else
		begin
			cnt <= next_cnt; // R10
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dir_up <= 1'b1;
		end
		else
		begin
			dir_up <= next_dir; // R2
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sq_high <= 1'b0;
		end
		else
		begin
			sq_high <= next_sq; // R5
		end
	end

	// read data holds until the next read
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_o <= 16'h0000;
		end
		else
		begin
			if (rd_en_i)
				rdata_o <= next_rdata; // R19
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			code_o <= '0;
		end
		else
		begin
			code_o <= code;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			locked_o <= 1'b0;
		end
		else
		begin
			locked_o <= lock;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			waveform_run_o <= 1'b0;
		end
		else
		begin
			waveform_run_o <= run;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pmbus_en_o <= 1'b0;
		end
		else
		begin
			pmbus_en_o <= next_pmbus; // R8
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			out_active_o <= 1'b0;
		end
		else
		begin
			out_active_o <= next_active; // R12
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			out_pulldown_o <= 1'b0;
		end
		else
		begin
			out_pulldown_o <= next_pulldown; // R12
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			out_hiz_o <= 1'b1;
		end
		else
		begin
			out_hiz_o <= next_hiz; // R12
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ref_internal_o <= 1'b0;
		end
		else
		begin
			ref_internal_o <= next_ref; // R14
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			output_gain_o <= 2'h0;
		end
		else
		begin
			output_gain_o <= next_gain; // R15
		end
	end
endmodule : dgc_general_config

// ===== dgc_pkg.sv
// constants for the dac general configuration block
package dgc_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam logic [7:0] ADDR_GENERAL_CONFIG = 8'hd1;
	localparam logic [7:0] ADDR_TRIGGER = 8'hd3;
	localparam logic [15:0] GENERAL_CONFIG_RESET = 16'h01f0;
	// general_config field positions
	localparam int WSEL_LSB = 14;
	localparam int LOCK_BIT = 13;
	localparam int PMBUS_BIT = 12;
	localparam int INC_LSB = 9;
	localparam int SLEW_LSB = 5;
	localparam int PDN_LSB = 3;
	localparam int REF_BIT = 2;
	localparam int GAIN_LSB = 0;
	// trigger fields
	localparam int KEY_LSB = 12;
	localparam int RUN_BIT = 8;
	localparam logic [3:0] UNLOCK_KEY = 4'h5;
	typedef enum logic [1:0] {DGC_TRIANGLE, DGC_SAW_UP, DGC_SAW_DOWN, DGC_SQUARE} dgc_wave_t;
	localparam logic [1:0] PDN_ACTIVE = 2'h0;
	localparam logic [1:0] PDN_HIZ = 2'h2;
	localparam logic [3:0] SLEW_NONE = 4'hf;
	localparam logic [3:0] SLEW_12US = 4'hd;
	localparam logic [3:0] SLEW_4US = 4'he;
	// step times in nanoseconds
	localparam int T_BASE0_NS = 25600;
	localparam int T_BASE1_NS = 204800;
	localparam int T_BASE2_NS = 1638400;
	localparam int T_12US_NS = 12000;
	localparam int T_4US_NS = 4000;
	localparam int BASE0_CYC = T_BASE0_NS / CLK_PERIOD_NS;
	localparam int BASE1_CYC = T_BASE1_NS / CLK_PERIOD_NS;
	localparam int BASE2_CYC = T_BASE2_NS / CLK_PERIOD_NS;
	localparam int STEP_12US_CYC = T_12US_NS / CLK_PERIOD_NS;
	localparam int STEP_4US_CYC = T_4US_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 21;
	localparam int CODE_W = 10;
endpackage : dgc_pkg

// ===== dgc_host.sv
// register host model driving the write and read strobes
`timescale 1ns/1ps
module dgc_host (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic wr_en_o = 1'h0,
	output logic rd_en_o = 1'h0,
	output logic [7:0] addr_o = 8'h00,
	output logic [15:0] wdata_o = 16'h0000
);
	task wr(input logic [7:0] a, input logic [15:0] w);
		@(negedge clk_i);
		{wr_en_o, addr_o, wdata_o} = {1'h1, a, w};
		@(negedge clk_i);
		wr_en_o = 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_i);
		{rd_en_o, addr_o} = {1'h1, a};
		@(negedge clk_i);
		rd_en_o = 1'h0;
		@(negedge clk_i);
		d = rdata_i;
	endtask : rd
endmodule : dgc_host

// ===== dgc_general_config_checker.sv
// port assertions for the general configuration block
`timescale 1ns/1ps
module dgc_general_config_checker
	import dgc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [15:0] rdata_o,
	input wire logic locked_o,
	input wire logic waveform_run_o,
	input wire logic pmbus_en_o,
	input wire logic out_active_o,
	input wire logic out_pulldown_o,
	input wire logic out_hiz_o,
	input wire logic ref_internal_o,
	input wire logic [1:0] output_gain_o
);
	wire logic wc = wr_en_i && addr_i == ADDR_GENERAL_CONFIG;
	wire logic wt = wr_en_i && addr_i == ADDR_TRIGGER;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_hiz_reset: assert property ($rose(resetn_i) |-> out_hiz_o && !out_active_o)
		else $error("output not high impedance after reset");
	a_pdn_onehot: assert property ($onehot({out_active_o, out_pulldown_o, out_hiz_o}))
		else $error("powerdown outputs not one-hot");
	a_gain_ref: assert property (!ref_internal_o |-> output_gain_o == 2'h0)
		else $error("gain set with supply reference");
	a_read_lock: assert property (rd_en_i && addr_i == ADDR_GENERAL_CONFIG |=> !rdata_o[LOCK_BIT])
		else $error("lock bit read back");
	a_read_trig: assert property (rd_en_i && addr_i == ADDR_TRIGGER |=> rdata_o == 16'h0000)
		else $error("trigger read not zero");
	a_lock_hold: assert property (locked_o && wc |=> ##1 $stable(pmbus_en_o))
		else $error("write taken while locked");
	a_unlock_key: assert property (wt && wdata_i[15:12] == UNLOCK_KEY |-> ##[1:2] !locked_o)
		else $error("key did not unlock");
	a_pmbus_write: assert property (!locked_o && wc |-> ##2 pmbus_en_o == $past(wdata_i[12], 2))
		else $error("pmbus enable wrong after write");
	a_run_start: assert property (!locked_o && wt |-> ##2 waveform_run_o == $past(wdata_i[8], 2))
		else $error("run state wrong after trigger write");
endmodule : dgc_general_config_checker
bind dgc_general_config dgc_general_config_checker i_dgc_general_config_checker (.*);

// ===== tb_top.sv
// self-checking bench for the general configuration block
`timescale 1ns/1ps
module tb_top;
	import dgc_pkg::*;
	logic clk_i = 1'h0, resetn_i = 1'h0, wr_en_i, rd_en_i, locked_o, waveform_run_o, pmbus_en_o;
	logic out_active_o, out_pulldown_o, out_hiz_o, ref_internal_o;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o, d;
	logic [9:0] target_code_i = 10'h000, margin_high_i = 10'h014, margin_low_i = 10'h00a, code_o;
	logic [1:0] output_gain_o;
	int n_fail = 0, cmp_count = 0;
	dgc_general_config #(.BASE0_CYCLES(8), .BASE1_CYCLES(16), .BASE2_CYCLES(32))
		i_dgc_general_config (.*);
	dgc_host i_dgc_host (.clk_i, .rdata_i(rdata_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
		.addr_o(addr_i), .wdata_o(wdata_i));
	initial forever #2 clk_i = ~clk_i;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task finish_test;
		$display("compares %0d errors %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task wait_code(input logic [9:0] v);
		for (int i = 0; i < 600 && code_o !== v; i++)
			@(negedge clk_i);
		chk(code_o, v);
		if (code_o !== v)
			finish_test();
	endtask : wait_code
	task t_reset;
		i_dgc_host.rd(ADDR_GENERAL_CONFIG, d);
		chk({d, out_hiz_o}, {GENERAL_CONFIG_RESET, 1'h1});
		i_dgc_host.rd(8'h21, d);
		chk(d, 16'h0000);
		i_dgc_host.rd(ADDR_TRIGGER, d);
		chk(d, 16'h0000);
	endtask : t_reset
	task t_fields;
		logic [15:0] w;
		for (int k = 0; k < 4; k++)
		begin
			w = {2'h3, 1'h0, k[0], 3'h5, 4'ha, k[1:0], k[1], k[1:0]};
			i_dgc_host.wr(ADDR_GENERAL_CONFIG, w);
			i_dgc_host.rd(ADDR_GENERAL_CONFIG, d);
			chk(d, w);
			chk({pmbus_en_o, out_active_o, out_pulldown_o, out_hiz_o}, {k[0], k == 0, k[0], k == 2});
			chk({ref_internal_o, output_gain_o}, {k[1], k[1] ? k[1:0] : 2'h0});
		end
	endtask : t_fields
	task t_lock;
		i_dgc_host.wr(ADDR_GENERAL_CONFIG, 16'h31f0);
		repeat (2) @(negedge clk_i);
		i_dgc_host.wr(ADDR_GENERAL_CONFIG, 16'h01f0);
		i_dgc_host.wr(ADDR_TRIGGER, 16'ha100);
		i_dgc_host.rd(ADDR_GENERAL_CONFIG, d);
		chk({d, locked_o, waveform_run_o}, {16'h11f0, 2'h2});
		i_dgc_host.wr(ADDR_TRIGGER, 16'h5000);
		repeat (2) @(negedge clk_i);
		i_dgc_host.wr(ADDR_GENERAL_CONFIG, 16'h01f0);
		i_dgc_host.rd(ADDR_GENERAL_CONFIG, d);
		chk({d, locked_o}, {16'h01f0, 1'h0});
	endtask : t_lock
	task t_slew;
		int n;
		target_code_i = 10'h155;
		wait_code(10'h155);
		i_dgc_host.wr(ADDR_GENERAL_CONFIG, 16'h0410);
		target_code_i = 10'h165;
		wait_code(10'h158);
		for (n = 0; code_o !== 10'h15b && n < 20; n++)
			@(negedge clk_i);
		chk(n, 8);
		wait_code(10'h164);
		wait_code(10'h165);
	endtask : t_slew
	task t_wave;
		i_dgc_host.wr(ADDR_GENERAL_CONFIG, 16'h01f0);
		target_code_i = 10'h00a;
		wait_code(10'h00a);
		for (int m = 0; m < 4; m++)
		begin
			i_dgc_host.wr(ADDR_GENERAL_CONFIG, {m[1:0], 14'h0010});
			i_dgc_host.wr(ADDR_TRIGGER, 16'h0100);
			wait_code(10'h014);
			wait_code(10'h00a);
			wait_code(10'h014);
			i_dgc_host.wr(ADDR_TRIGGER, 16'h0000);
			@(negedge clk_i);
			chk(waveform_run_o, 1'h0);
		end
	endtask : t_wave
	initial
	begin
		repeat (16) @(negedge clk_i);
		resetn_i = 1'h1;
		t_reset();
		t_fields();
		t_lock();
		t_slew();
		t_wave();
		finish_test();
	end
endmodule : tb_top
